// ### core/lccd_pkg.sv
// Shared constants and types for the character display command decoder.
// Assumes a single 25 MHz clock and no register bus; all state leaves as ports.
package lccd_pkg;

  // ****************************************************************
  // Command opcodes (upper nibble) and whole-byte codes
  // ****************************************************************
  localparam logic [3:0] OP_HOME        = 4'h1;
  localparam logic [3:0] OP_STATIC      = 4'h2;
  localparam logic [3:0] OP_DISPLAY     = 4'h3;
  localparam logic [3:0] OP_POWER_SAVE  = 4'h4;
  localparam logic [3:0] OP_POWER_CTRL  = 4'h5;
  localparam logic [3:0] OP_SYSTEM      = 4'h6;
  localparam logic [3:0] OP_CONTRAST    = 4'h7;
  localparam logic [7:0] CODE_NOP       = 8'h00;
  localparam logic [7:0] CODE_TEST      = 8'h0a;

  // ****************************************************************
  // Address map of the shared counter
  // ****************************************************************
  localparam logic [6:0] ADDR_RESET     = 7'h00;
  localparam logic [6:0] ADDR_HOME      = 7'h30;
  localparam logic [6:0] UCR_LAST       = 7'h1f;
  localparam logic [6:0] LINE1_BASE     = 7'h30;
  localparam logic [6:0] LINE2_BASE     = 7'h40;
  localparam logic [6:0] LINE3_BASE     = 7'h50;
  localparam logic [6:0] LINE4_BASE     = 7'h60;
  localparam logic [6:0] SYMBOL_BASE    = 7'h70;
  localparam logic [7:0] USER_CODE_LAST = 8'h03;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] CONTRAST_RESET = 4'h0;
  localparam logic [1:0] LINES_RESET    = 2'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_HZ          = 25_000_000;
  localparam int TICK_MS           = 1;
  localparam int TICK_CYCLES       = CLOCK_HZ / 1000 * TICK_MS;
  localparam int CURSOR_PERIOD_MS  = 1000;
  localparam int SLOW_PERIOD_MS    = 667;
  localparam int FAST_PERIOD_MS    = 286;
  localparam logic [9:0] CURSOR_HALF_TICKS = 10'(CURSOR_PERIOD_MS / 2 / TICK_MS);
  localparam logic [9:0] SLOW_HALF_TICKS   = 10'(SLOW_PERIOD_MS / 2 / TICK_MS);
  localparam logic [9:0] FAST_HALF_TICKS   = 10'(FAST_PERIOD_MS / 2 / TICK_MS);

  typedef enum logic [1:0] {
    STATIC_OFF  = 2'b00,
    STATIC_SLOW = 2'b01,
    STATIC_FAST = 2'b10,
    STATIC_ON   = 2'b11
  } lccd_static_mode_t;

  typedef struct packed {
    lccd_static_mode_t static_mode;
    logic              cursor_shown;
    logic              cursor_blink;
    logic              double_cursor;
    logic              display_on;
    logic              osc_run;
    logic              power_save;
    logic              regulator_en;
    logic              follower_en;
    logic              booster_en;
    logic              user_ram_en;
    logic              line_count_hi;
    logic              line_count_lo;
  } lccd_flags_t;

  typedef struct packed {
    logic       reg_select;
    logic [7:0] data;
  } lccd_host_t;

  typedef struct packed {
    logic       shown;
    logic       reverse;
    logic [6:0] addr;
  } lccd_cursor_t;

endpackage : lccd_pkg

// ### core/lccd_char_rom.sv
// Fixed character pattern table, 256 codes by 7 rows of 5 dots.
// Assumes the caller registers the output; the lookup is purely combinational.
`timescale 1ns/1ps

module lccd_char_rom (
  input  wire logic [7:0] i_code,
  input  wire logic [2:0] i_row,
  output logic      [4:0] o_dots
);

  // ****************************************************************
  // Pattern generation
  // ****************************************************************
  // The mask contents are product specific; this stand-in derives a
  // repeatable pattern per code, 32 distinct patterns in all, so that the lookup is testable.
  logic [4:0] mixed;
  logic       blank_row;

  assign mixed     = i_code[4:0] ^ {i_row, 2'b00} ^ {2'b00, i_code[7:5]};
  assign blank_row = (i_row == 3'h7);
  assign o_dots    = blank_row ? 5'h00 : mixed;

endmodule : lccd_char_rom

// ### core/lccd_decoder.sv
// Command interpreter of a character dot-matrix display controller.
// Assumes host pins are asynchronous to i_clock and held per write cycle time.
`timescale 1ns/1ps

// Summary of operation
// - Cursor home loads counter with 30H.
// - Static command sets two-bit symbol mode.
// - Static symbol acts only in standby.
// - Display command loads cursor, blink, double, display.
// - Cursor hidden, reverse, or alternating by flags.
// - Cursor blink period about one second.
// - Cursor follows the address counter.
// - Symbol area cursor blinks symbols selectively.
// - Power save sets oscillator and save flags.
// - Power control sets regulator, follower, booster.
// - System set loads line count, user RAM.
// - Contrast command loads four-bit level.
// - Bit seven set loads seven-bit address.
// - Data byte stored at counter location.
// - Counter increments after every data write.
// - Codes 00H-03H from user RAM if enabled.
// - Fixed 256-entry 5x7 pattern table.
// - Reset clears mode, display and power flags.
// - Power save enters standby, keeps contents.
module lccd_decoder #(
  parameter int P_TICK_CYCLES = lccd_pkg::TICK_CYCLES,
  parameter int P_SYNC_WIDTH  = 10
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic                  i_write_strobe,
  input  wire logic                  i_reg_select,
  input  wire logic [7:0]            i_data,
  input  wire logic [6:0]            i_view_addr,
  input  wire logic [7:0]            i_char_code,
  input  wire logic [2:0]            i_char_row,
  output lccd_pkg::lccd_flags_t      o_flags,
  output logic      [3:0]            o_contrast,
  output logic      [6:0]            o_addr_counter,
  output lccd_pkg::lccd_cursor_t     o_cursor,
  output logic                       o_symbol_blink,
  output logic                       o_static_symbol_on,
  output logic                       o_standby,
  output logic      [7:0]            o_view_data,
  output logic      [4:0]            o_pattern_row
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit layout: [9] write strobe, [8] register select, [7:0] data.
  logic [P_SYNC_WIDTH-1:0] pins;
  logic [P_SYNC_WIDTH-1:0] sync1;
  logic [P_SYNC_WIDTH-1:0] sync2;
  logic [P_SYNC_WIDTH-1:0] sync3;
  logic [P_SYNC_WIDTH-1:0] stable;
  logic                    strobe_seen;

  assign pins = {i_write_strobe, i_reg_select, i_data};

  genvar gi;
  generate
    for (gi = 0; gi < P_SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge i_clock) begin
        sync1[gi] <= pins[gi];
        sync2[gi] <= sync1[gi];
        sync3[gi] <= sync2[gi];
        if (i_rst) begin
          stable[gi] <= 1'b0;
        end else if (sync2[gi] == sync3[gi]) begin
          stable[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      strobe_seen <= 1'b0;
    end else begin
      strobe_seen <= stable[9];
    end
  end

  // ****************************************************************
  // Byte decode
  // ****************************************************************
  lccd_pkg::lccd_host_t host;
  logic                 write_event;
  logic                 is_cmd;
  logic                 is_data;
  logic [3:0]           opcode;
  logic                 do_home;
  logic                 do_static;
  logic                 do_display;
  logic                 do_save;
  logic                 do_power;
  logic                 do_system;
  logic                 do_contrast;
  logic                 do_address;

  assign host        = lccd_pkg::lccd_host_t'(stable[8:0]);
  assign write_event = stable[9] & ~strobe_seen;
  assign is_cmd      = write_event & ~host.reg_select;
  assign is_data     = write_event & host.reg_select;
  assign opcode      = host.data[7:4];
  // Codes 00H (no-op), 0AH (test) and other 0xH bytes fall through every
  // decode below and therefore change nothing.
  assign do_home     = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_HOME);
  assign do_static   = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_STATIC);
  assign do_display  = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_DISPLAY);
  assign do_save     = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_POWER_SAVE);
  assign do_power    = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_POWER_CTRL)
                       & ~host.data[3];
  assign do_system   = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_SYSTEM);
  assign do_contrast = is_cmd & ~host.data[7] & (opcode == lccd_pkg::OP_CONTRAST);
  assign do_address  = is_cmd & host.data[7];

  // ****************************************************************
  // Control flags
  // ****************************************************************
  lccd_pkg::lccd_flags_t flags;
  logic [3:0]            contrast;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flags    <= '0;
      contrast <= lccd_pkg::CONTRAST_RESET;
    end else begin
      if (do_static) begin
        flags.static_mode <= lccd_pkg::lccd_static_mode_t'(host.data[1:0]);
      end
      if (do_display) begin
        flags.cursor_shown  <= host.data[3];
        flags.cursor_blink  <= host.data[2];
        flags.double_cursor <= host.data[1];
        flags.display_on    <= host.data[0];
      end
      if (do_save) begin
        flags.osc_run    <= host.data[1];
        flags.power_save <= host.data[0];
      end
      if (do_power) begin
        flags.regulator_en <= host.data[2];
        flags.follower_en  <= host.data[1];
        flags.booster_en   <= host.data[0];
      end
      if (do_system) begin
        flags.line_count_hi <= host.data[3];
        flags.line_count_lo <= host.data[2];
        flags.user_ram_en   <= host.data[0];
      end
      if (do_contrast) begin
        contrast <= host.data[3:0];
      end
    end
  end

  // ****************************************************************
  // Address counter and storage
  // ****************************************************************
  // Unmapped holes are still counted through, but writes there are dropped.
  logic [6:0] addr;
  logic [6:0] next_addr;
  logic [7:0] mem [128];
  logic       in_user;
  logic       in_line;
  logic       in_symbol;
  logic       mapped;

  assign in_user   = (addr <= lccd_pkg::UCR_LAST);
  assign in_line   = (addr >= lccd_pkg::LINE1_BASE) & (addr < lccd_pkg::SYMBOL_BASE);
  assign in_symbol = (addr >= lccd_pkg::SYMBOL_BASE);
  assign mapped    = in_user | in_line | in_symbol;

  always_comb begin
    next_addr = addr;
    if (do_home) begin
      next_addr = lccd_pkg::ADDR_HOME;
    end else if (do_address) begin
      next_addr = host.data[6:0];
    end else if (is_data) begin
      next_addr = addr + 7'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      addr <= lccd_pkg::ADDR_RESET;
    end else begin
      addr <= next_addr;
    end
  end

  // Storage is not cleared by reset or standby, so contents survive both.
  always_ff @(posedge i_clock) begin
    if (is_data && mapped) begin
      mem[addr] <= host.data;
    end
  end

  // ****************************************************************
  // Internal timing: millisecond tick and blink phases
  // ****************************************************************
  // Timing only advances while the oscillator flag is set, as on the chip.
  logic [$clog2(P_TICK_CYCLES)-1:0] tick_count;
  logic                             tick;
  logic [2:0][9:0]                  half_ticks;
  logic [2:0][9:0]                  blink_count;
  logic [2:0]                       blink_phase;
  logic                             cursor_phase;

  assign tick = flags.osc_run
                & (tick_count == ($clog2(P_TICK_CYCLES))'(P_TICK_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst || !flags.osc_run || tick) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + 1'b1;
    end
  end

  // Entry 0 paces the cursor, entries 1 and 2 the slow and fast static blink.
  assign half_ticks   = {lccd_pkg::FAST_HALF_TICKS, lccd_pkg::SLOW_HALF_TICKS,
                         lccd_pkg::CURSOR_HALF_TICKS};
  assign cursor_phase = blink_phase[0];

  genvar bi;
  generate
    for (bi = 0; bi < 3; bi++) begin : g_blink
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          blink_count[bi] <= '0;
          blink_phase[bi] <= 1'b0;
        end else if (tick) begin
          if (blink_count[bi] == half_ticks[bi] - 10'h001) begin
            blink_count[bi] <= '0;
            blink_phase[bi] <= ~blink_phase[bi];
          end else begin
            blink_count[bi] <= blink_count[bi] + 10'h001;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Cursor, symbol and static outputs
  // ****************************************************************
  logic [3:0] static_sel;
  logic       next_static;
  logic       cursor_reverse;
  logic       symbol_blink;

  // Indexed by the static mode code: off, slow blink, fast blink, on.
  assign static_sel  = {1'b1, blink_phase[2], blink_phase[1], 1'b0};
  assign next_static = static_sel[flags.static_mode];

  // Steady reverse without blink; alternating reverse with blink.
  assign cursor_reverse = flags.cursor_shown & (~flags.cursor_blink | cursor_phase);
  assign symbol_blink   = flags.cursor_shown & ~flags.cursor_blink & in_symbol;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_cursor           <= '0;
      o_symbol_blink     <= 1'b0;
      o_static_symbol_on <= 1'b0;
      o_standby          <= 1'b0;
    end else begin
      o_cursor.shown     <= flags.cursor_shown;
      o_cursor.reverse   <= cursor_reverse;
      o_cursor.addr      <= addr;
      o_symbol_blink     <= symbol_blink & cursor_phase;
      o_static_symbol_on <= flags.power_save & flags.osc_run & next_static;
      o_standby          <= flags.power_save;
    end
  end

  // ****************************************************************
  // Pattern and view read ports
  // ****************************************************************
  logic [4:0] rom_dots;
  logic       use_user;
  logic [6:0] user_index;
  logic [4:0] user_dots;

  lccd_char_rom u_rom (
    .i_code (i_char_code),
    .i_row  (i_char_row),
    .o_dots (rom_dots)
  );

  assign use_user   = flags.user_ram_en & (i_char_code <= lccd_pkg::USER_CODE_LAST);
  assign user_index = {2'b00, i_char_code[1:0], i_char_row};
  assign user_dots  = (i_char_row == 3'h7) ? 5'h00 : mem[user_index][4:0];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pattern_row <= '0;
      o_view_data   <= '0;
    end else begin
      o_pattern_row <= use_user ? user_dots : rom_dots;
      o_view_data   <= mem[i_view_addr];
    end
  end

  // ****************************************************************
  // Register outputs
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_flags        <= '0;
      o_contrast     <= lccd_pkg::CONTRAST_RESET;
      o_addr_counter <= lccd_pkg::ADDR_RESET;
    end else begin
      o_flags        <= flags;
      o_contrast     <= contrast;
      o_addr_counter <= addr;
    end
  end

endmodule : lccd_decoder

// ### verification/lccd_decoder_props.sv
// Port checker for the display command decoder.
// Assumes the bind below attaches it to every lccd_decoder instance.
`timescale 1ns/1ps
module lccd_decoder_props #(
  parameter int P_TICK_CYCLES = lccd_pkg::TICK_CYCLES
) (
  input wire logic                   i_clock,
  input wire logic                   i_rst,
  input wire logic                   i_write_strobe,
  input wire logic [2:0]             i_char_row,
  input wire lccd_pkg::lccd_flags_t  o_flags,
  input wire logic [6:0]             o_addr_counter,
  input wire lccd_pkg::lccd_cursor_t o_cursor,
  input wire logic                   o_symbol_blink,
  input wire logic                   o_static_symbol_on,
  input wire logic                   o_standby,
  input wire logic [4:0]             o_pattern_row
);
  // ****************************************************************
  // Cycles since the host strobe last rose
  // ****************************************************************
  // State may only move shortly after a strobe; the synchroniser needs about six edges.
  logic       strobe_q;
  logic [3:0] since_rise;
  always_ff @(posedge i_clock) begin
    strobe_q <= i_write_strobe;
    if (i_rst) since_rise <= 4'hf;
    else if (i_write_strobe && !strobe_q) since_rise <= 4'h0;
    else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_reset_clears_state: assert property (
      $past(i_rst) |-> o_flags == '0 && o_addr_counter == 7'h00)
    else $error("state not clear after reset");
  a_flags_need_write: assert property (
      $changed(o_flags) |-> since_rise < 4'hc)
    else $error("flags changed without a write");
  a_counter_need_write: assert property (
      $changed(o_addr_counter) |-> since_rise < 4'hc)
    else $error("counter changed without a write");
  a_standby_is_save: assert property (
      o_standby == o_flags.power_save)
    else $error("standby differs from power save flag");
  a_static_in_standby: assert property (
      o_static_symbol_on |-> o_standby && o_flags.osc_run)
    else $error("static symbol lit outside standby");
  a_static_mode_off: assert property (
      (o_flags.static_mode == lccd_pkg::STATIC_OFF) [*2] |-> !o_static_symbol_on)
    else $error("static symbol lit in off mode");
  a_cursor_hidden: assert property (
      (!o_flags.cursor_shown) [*2] |-> !o_cursor.shown && !o_cursor.reverse)
    else $error("cursor visible while hidden");
  a_reverse_steady: assert property (
      (o_flags.cursor_shown && !o_flags.cursor_blink) [*2] |-> o_cursor.reverse)
    else $error("steady cursor not reversed");
  a_cursor_tracks_counter: assert property (
      $stable(o_addr_counter) |-> o_cursor.addr == o_addr_counter)
    else $error("cursor address differs from counter");
  a_symbol_blink_cause: assert property (
      o_symbol_blink && $stable(o_flags) && $stable(o_addr_counter) |->
      o_addr_counter >= 7'h70 && o_flags.cursor_shown && !o_flags.cursor_blink)
    else $error("symbol blink without its cause");
  a_blank_row_seven: assert property (
      i_char_row == 3'h7 |=> o_pattern_row == 5'h00)
    else $error("pattern row seven not blank");

  cover property (o_symbol_blink);
  cover property (o_static_symbol_on);
  cover property ($rose(o_cursor.reverse) && o_flags.cursor_blink);
endmodule : lccd_decoder_props

bind lccd_decoder lccd_decoder_props #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_write_strobe(i_write_strobe),
  .i_char_row(i_char_row), .o_flags(o_flags), .o_addr_counter(o_addr_counter),
  .o_cursor(o_cursor), .o_symbol_blink(o_symbol_blink),
  .o_static_symbol_on(o_static_symbol_on), .o_standby(o_standby),
  .o_pattern_row(o_pattern_row));

// ### verification/lccd_host_model.sv
// Host processor model writing command and data bytes on the decoder pins.
// Assumes the decoder synchronises the pins to i_clock; pins change at falling edges.
`timescale 1ns/1ps
module lccd_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  output logic            o_write_strobe,
  output logic            o_reg_select,
  output logic [7:0]      o_data
);
  int   misuse = 0;
  int   resets = 0;
  int   resets_known = 0;
  logic system_done = 1'b0;
  logic osc_on = 1'b0;
  initial begin
    o_write_strobe = 1'b0;
    o_reg_select = 1'b0;
    o_data = 8'h00;
  end
  // Counting reset edges here keeps the task the only writer of its flags.
  always @(posedge i_clock) begin
    if (i_rst) begin
      resets <= resets + 1;
    end
  end

  // ****************************************************************
  // One write cycle
  // ****************************************************************
  task automatic send(input logic rs, input logic [7:0] b);
    if (resets != resets_known) begin
      resets_known = resets;
      system_done = 1'b0;
      osc_on = 1'b0;
    end
    if (!rs && !system_done && b[7:4] != 4'h6) misuse++;
    if (!rs && b[7:3] == 5'h0a && b[0] && !osc_on) misuse++;
    if (!rs && b == lccd_pkg::CODE_TEST) misuse++;
    if (!rs && b[7:4] == 4'h6) system_done = 1'b1;
    if (!rs && b[7:4] == 4'h4) osc_on = b[1];
    @(negedge i_clock);
    o_reg_select = rs;
    o_data = b;
    repeat (4) @(negedge i_clock);
    o_write_strobe = 1'b1;
    repeat (5) @(negedge i_clock);
    o_write_strobe = 1'b0;
    repeat (5) @(negedge i_clock);
    // Past the hold time the bus no longer shows the byte.
    o_data = ~b;
    o_reg_select = ~rs;
    repeat (6) @(negedge i_clock);
  endtask : send
endmodule : lccd_host_model

// ### verification/lccd_decoder_tb_top.sv
// Self-checking bench for the display command decoder.
// Assumes the host model drives the pins and the checker is bound to the decoder.
`timescale 1ns/1ps
module lccd_decoder_tb_top;
  localparam int TICK = 4;
  localparam int HALF = 500 * TICK;
  logic                   i_clock;
  logic                   i_rst = 1'b1;
  logic                   strobe;
  logic                   rs;
  logic [7:0]             data;
  logic [6:0]             view_addr;
  logic [7:0]             char_code;
  logic [2:0]             char_row;
  lccd_pkg::lccd_flags_t  flags;
  lccd_pkg::lccd_cursor_t cursor;
  logic [3:0]             contrast;
  logic [6:0]             addr_counter;
  logic                   symbol_blink;
  logic                   static_on;
  logic                   standby;
  logic [7:0]             view_data;
  logic [4:0]             pattern_row;
  lccd_pkg::lccd_flags_t  ef;
  logic [3:0]             ec;
  logic [6:0]             ea;
  int                     bad_count = 0;
  int                     checks_done = 0;
  int                     n;
  logic [2:0]             watch;

  lccd_decoder #(.P_TICK_CYCLES(TICK)) uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_write_strobe(strobe), .i_reg_select(rs),
    .i_data(data), .i_view_addr(view_addr), .i_char_code(char_code),
    .i_char_row(char_row), .o_flags(flags), .o_contrast(contrast),
    .o_addr_counter(addr_counter), .o_cursor(cursor), .o_symbol_blink(symbol_blink),
    .o_static_symbol_on(static_on), .o_standby(standby), .o_view_data(view_data),
    .o_pattern_row(pattern_row));
  lccd_host_model host (
    .i_clock(i_clock), .i_rst(i_rst), .o_write_strobe(strobe), .o_reg_select(rs),
    .o_data(data));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  initial begin
    repeat (40000) @(posedge i_clock);
    bad_count++;
    $display("Error watchdog expected finish seen hang");
    wrap_up();
  end

  // ****************************************************************
  // Checking tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cmd(input logic r, input logic [7:0] b);
    host.send(r, b);
    chk("flags", flags, ef);
    chk("counter", {9'h0, addr_counter}, {9'h0, ea});
    chk("contrast", {12'h0, contrast}, {12'h0, ec});
  endtask : cmd
  // Watched levels: 0 cursor reverse, 1 symbol blink, 2 static symbol.
  assign watch = {static_on, symbol_blink, cursor.reverse};
  task automatic wait_flip(input int sel, output int k);
    logic r;
    r = watch[sel];
    k = 0;
    while (watch[sel] === r && k < 3 * HALF) begin
      @(negedge i_clock);
      k++;
    end
  endtask : wait_flip
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    ef = '0;
    ec = 4'h0;
    ea = 7'h00;
    view_addr = 7'h00;
    char_code = 8'h00;
    char_row = 3'h0;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    chk("reset flags", flags, 16'h0);
    for (int i = 0; i < 3; i++) begin
      ef.line_count_hi = i[1];
      ef.line_count_lo = i[0];
      ef.user_ram_en = 1'b1;
      cmd(1'b0, {4'h6, i[1:0], 2'b11});
    end
    for (int v = 0; v < 16; v++) begin
      {ef.cursor_shown, ef.cursor_blink, ef.double_cursor, ef.display_on} = v[3:0];
      cmd(1'b0, {4'h3, v[3:0]});
    end
    ef.osc_run = 1'b1;
    ef.power_save = 1'b1;
    cmd(1'b0, 8'h4f);
    chk("standby", standby, 16'h1);
    for (int m = 0; m < 4; m++) begin
      ef.static_mode = lccd_pkg::lccd_static_mode_t'(m[1:0]);
      cmd(1'b0, {6'h0b, m[1:0]});
    end
    chk("static on", static_on, 16'h1);
    ef.static_mode = lccd_pkg::STATIC_SLOW;
    cmd(1'b0, 8'h21);
    wait_flip(2, n);
    wait_flip(2, n);
    chk("slow half", n >= 250 * TICK && n <= 500 * TICK, 16'h1);
    ef.static_mode = lccd_pkg::STATIC_FAST;
    cmd(1'b0, 8'h22);
    wait_flip(2, n);
    wait_flip(2, n);
    chk("fast half", n >= 125 * TICK && n <= 167 * TICK, 16'h1);
    ef.power_save = 1'b0;
    cmd(1'b0, 8'h42);
    chk("static off", static_on, 16'h0);
    {ef.regulator_en, ef.follower_en, ef.booster_en} = 3'b111;
    cmd(1'b0, 8'h57);
    cmd(1'b0, 8'h5d);
    {ef.regulator_en, ef.follower_en, ef.booster_en} = 3'b010;
    cmd(1'b0, 8'h52);
    ec = 4'hf;
    cmd(1'b0, 8'h7f);
    ec = 4'h0;
    cmd(1'b0, 8'h70);
    cmd(1'b0, 8'h00);
    cmd(1'b0, 8'h05);
    ea = 7'h30;
    cmd(1'b0, 8'h1a);
    chk("cursor addr", {9'h0, cursor.addr}, 16'h30);
    ea = 7'h7f;
    cmd(1'b0, 8'hff);
    ea = 7'h00;
    cmd(1'b1, 8'h15);
    ea = 7'h01;
    cmd(1'b1, 8'h0a);
    view_addr = 7'h7f;
    @(negedge i_clock);
    chk("view 7f", view_data, 16'h15);
    view_addr = 7'h00;
    @(negedge i_clock);
    chk("view 00", view_data, 16'h0a);
    chk("user row", pattern_row, 16'h0a);
    char_row = 3'h7;
    @(negedge i_clock);
    chk("row seven", pattern_row, 16'h0);
    char_row = 3'h0;
    ef.user_ram_en = 1'b0;
    cmd(1'b0, 8'h68);
    chk("rom row", pattern_row, 16'h0);
    ea = 7'h70;
    cmd(1'b0, 8'hf0);
    {ef.cursor_shown, ef.cursor_blink, ef.double_cursor, ef.display_on} = 4'hc;
    cmd(1'b0, 8'h3c);
    wait_flip(0, n);
    wait_flip(0, n);
    chk("blink half", n > HALF - 2 * TICK && n < HALF + 2 * TICK, 16'h1);
    ef.cursor_blink = 1'b0;
    cmd(1'b0, 8'h38);
    chk("steady reverse", cursor.reverse, 16'h1);
    wait_flip(1, n);
    wait_flip(1, n);
    chk("symbol half", n > HALF - 2 * TICK && n < HALF + 2 * TICK, 16'h1);
    ea = 7'h30;
    cmd(1'b0, 8'hb0);
    chk("no symbol blink", symbol_blink, 16'h0);
    ef.cursor_shown = 1'b0;
    cmd(1'b0, 8'h30);
    chk("cursor hidden", cursor.shown, 16'h0);
    chk("host misuse", 16'(host.misuse), 16'h0);
    i_rst = 1'b1;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    chk("rerun flags", flags, 16'h0);
    chk("rerun counter", {9'h0, addr_counter}, 16'h0);
    wrap_up();
  end
endmodule : lccd_decoder_tb_top
